//--- hdl/in_sync.sv
// Two-flop synchroniser for a group of pin levels.
`timescale 1ns/10ps
`default_nettype none
module in_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

//--- hdl/io_register_space_decode.sv
// Lower I/O register space: address views, bit access, flag clearing and storage.
`include "io_space_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module io_register_space_decode
  import io_space_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire io_req_s REQ,
  input wire port_pins_s PINS,
  input wire flag_vec_s EVENTS,
  input wire logic SPI_DONE,
  input wire logic SPI_COLLISION,
  output io_resp_s RESP,
  output pin_ctrl_s PIN_CTRL,
  output flag_vec_s FLAGS,
  output periph_cfg_s PERIPH_CFG
);

  ////////////////////////////////////////////////////////////////////////////////
  // Writable-bit mask of each location; zero marks reserved bits and addresses, and also the pin and flag registers.

  function automatic logic [7:0] write_mask(input logic [5:0] a);
    logic [7:0] m;
    m = 8'h00;
    unique case (a)
      `A_PORT_B_OUTPUT_LATCH_DIR, `A_PORT_B_OUTPUT_LATCH_OUT: m = `M_FULL;
      `A_PORT_C_OUTPUT_LATCH_DIR, `A_PORT_C_OUTPUT_LATCH_OUT: m = `M_FULL;
      `A_PORT_D_OUTPUT_LATCH_DIR, `A_PORT_D_OUTPUT_LATCH_OUT: m = `M_FULL;
      `A_PORT_A_OUTPUT_LATCH_DIR, `A_PORT_A_OUTPUT_LATCH_OUT: m = `M_PORT_A_OUTPUT_LATCH;
      `A_PULLUP_CTRL: m = `M_FULL;
      `A_EXT_MASK: m = `M_EXT;
      `A_GP0, `A_GP1, `A_GP2: m = `M_FULL;
      `A_EE_CTRL: m = `M_EE_CTRL;
      `A_EE_DATA, `A_EE_ADDR: m = `M_FULL;
      `A_PRESC_CTRL: m = `M_PRESC;
      `A_T0_CTRL: m = `M_T0_CTRL;
      `A_T0_COUNT, `A_T0_CMP_A, `A_T0_CMP_B: m = `M_FULL;
      `A_SPI_CTRL: m = `M_FULL;
      `A_SPI_STAT: m = `M_SPI_STAT_W;
      default: m = 8'h00; // [R11]
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Address views.

  logic [7:0] store_r [0:`IO_LOCATIONS-1];
  port_pins_s pins_s;
  flag_vec_s flag_q;
  io_resp_s resp_nxt;
  logic [7:0] rd_val;

  wire is_io_kind = (REQ.kind != MEMORY_READ_OP) && (REQ.kind != MEMORY_WRITE_OP);
  // Only the low six bits exist in the instruction field.
  wire [5:0] io_field = REQ.addr[5:0]; // [R7] [R9]
  wire [7:0] data_off = REQ.addr - `DATA_IO_BASE;
  wire mem_in_io = (REQ.addr >= `DATA_IO_BASE) && (REQ.addr < `DATA_EXT_BASE); // [R8]
  wire mem_ext = REQ.addr >= `DATA_EXT_BASE; // [R10]
  wire [5:0] io_addr = is_io_kind ? io_field : data_off[5:0]; // [R8]
  wire hit = REQ.valid && (is_io_kind || mem_in_io);
  wire ext_hit = REQ.valid && !is_io_kind && mem_ext; // [R10]
  wire bit_ok = io_addr <= `IO_BIT_TOP; // [R3]

  ////////////////////////////////////////////////////////////////////////////////
  // Access kinds.

  wire kind_write = (REQ.kind == IO_WRITE_INSTR) || (REQ.kind == MEMORY_WRITE_OP);
  wire kind_set = (REQ.kind == SET_IO_BIT_INSTR) && bit_ok; // [R3]
  wire kind_clr = (REQ.kind == CLEAR_IO_BIT_INSTR) && bit_ok; // [R3]
  wire kind_skip_s = (REQ.kind == SKIP_IF_BIT_SET_INSTR) && bit_ok; // [R4]
  wire kind_skip_c = (REQ.kind == SKIP_IF_BIT_CLEAR_INSTR) && bit_ok; // [R4]
  wire [7:0] one_hot = 8'h01 << REQ.bit_sel;

  // Ones written at this access: a whole byte, or only the addressed bit.
  wire [7:0] ones_written = kind_write ? REQ.wdata : (kind_set ? one_hot : 8'h00); // [R6]
  wire [7:0] clr_vec = hit ? ones_written : 8'h00; // [R5]

  wire [7:0] wmask = write_mask(io_addr);
  wire [7:0] cur_store = store_r[io_addr];
  wire [7:0] bit_result = kind_set ? (cur_store | one_hot) : (cur_store & ~one_hot);
  wire [7:0] new_byte = kind_write ? REQ.wdata : bit_result; // [R6]
  wire store_we = hit && (kind_write || kind_set || kind_clr) && (wmask != 8'h00); // [R11]

  ////////////////////////////////////////////////////////////////////////////////
  // Input pins register: writing one toggles the matching output latch bit.

  wire pin_addr = (io_addr == `A_PORT_A_OUTPUT_LATCH_PIN) || (io_addr == `A_PORT_B_OUTPUT_LATCH_PIN)
    || (io_addr == `A_PORT_C_OUTPUT_LATCH_PIN) || (io_addr == `A_PORT_D_OUTPUT_LATCH_PIN);
  wire [5:0] latch_addr = 6'(io_addr + `PIN_TO_LATCH);
  wire [7:0] latch_mask = write_mask(latch_addr);
  wire toggle_we = hit && pin_addr && (ones_written != 8'h00); // [R6]
  wire [7:0] toggled = store_r[latch_addr] ^ (ones_written & latch_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin levels come from outside the clock domain.

  in_sync #(
    .W($bits(port_pins_s))
  ) u_pin_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .async_in(PINS),
    .sync_out(pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Write-one-to-clear flag registers.

  wire [7:0] clr_t0 = (io_addr == `A_T0_FLAGS) ? clr_vec : 8'h00; // [R5]
  wire [7:0] clr_t1 = (io_addr == `A_T1_FLAGS) ? clr_vec : 8'h00; // [R5]
  wire [7:0] clr_pc = (io_addr == `A_PC_FLAGS) ? clr_vec : 8'h00; // [R5]
  wire [7:0] clr_ext = (io_addr == `A_EXT_FLAGS) ? clr_vec : 8'h00; // [R5]

  w1c_flag_reg #(
    .MASK(`M_T0_FLAGS)
  ) u_t0_flags (
    .clk(CLK),
    .rst_b(RST_B),
    .set_ev(EVENTS.t0),
    .clr_ones(clr_t0),
    .flags(flag_q.t0)
  );

  w1c_flag_reg #(
    .MASK(`M_T1_FLAGS)
  ) u_t1_flags (
    .clk(CLK),
    .rst_b(RST_B),
    .set_ev(EVENTS.t1),
    .clr_ones(clr_t1),
    .flags(flag_q.t1)
  );

  w1c_flag_reg #(
    .MASK(`M_PC_FLAGS)
  ) u_pc_flags (
    .clk(CLK),
    .rst_b(RST_B),
    .set_ev(EVENTS.pc),
    .clr_ones(clr_pc),
    .flags(flag_q.pc)
  );

  w1c_flag_reg #(
    .MASK(`M_EXT)
  ) u_ext_flags (
    .clk(CLK),
    .rst_b(RST_B),
    .set_ev(EVENTS.ext),
    .clr_ones(clr_ext),
    .flags(flag_q.ext)
  );

  assign FLAGS = flag_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Plain storage. Reserved positions never load, so they stay at zero.

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      for (int i = 0; i < `IO_LOCATIONS; i++)
        store_r[i] <= `RESET_BYTE;
    end
    else if (store_we)
      store_r[io_addr] <= (cur_store & ~wmask) | (new_byte & wmask); // [R6] [R11]
    else if (toggle_we)
      store_r[latch_addr] <= toggled;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read selection. Status comes from live state, storage from the array.

  always_comb
  begin
    rd_val = cur_store & wmask; // [R11]
    unique case (io_addr)
      `A_PORT_A_OUTPUT_LATCH_PIN: rd_val = {4'h0, pins_s.a};
      `A_PORT_B_OUTPUT_LATCH_PIN: rd_val = pins_s.b;
      `A_PORT_C_OUTPUT_LATCH_PIN: rd_val = pins_s.c;
      `A_PORT_D_OUTPUT_LATCH_PIN: rd_val = pins_s.d;
      `A_T0_FLAGS: rd_val = flag_q.t0;
      `A_T1_FLAGS: rd_val = flag_q.t1;
      `A_PC_FLAGS: rd_val = flag_q.pc;
      `A_EXT_FLAGS: rd_val = flag_q.ext;
      `A_SPI_STAT:
      begin
        rd_val = cur_store & wmask;
        rd_val[`B_SPI_DONE] = SPI_DONE;
        rd_val[`B_SPI_COLL] = SPI_COLLISION;
      end
      default: rd_val = cur_store & wmask; // [R11]
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Answer, one cycle after the request.

  wire read_kind = (REQ.kind == IO_READ_INSTR) || (REQ.kind == MEMORY_READ_OP);
  wire tested_bit = rd_val[REQ.bit_sel];

  always_comb
  begin
    resp_nxt.ack = REQ.valid;
    resp_nxt.rdata = (hit && read_kind) ? rd_val : 8'h00; // [R11]
    resp_nxt.skip = hit && ((kind_skip_s && tested_bit) || (kind_skip_c && !tested_bit)); // [R4]
    resp_nxt.ext_sel = ext_hit; // [R10]
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      RESP <= '0;
    else
      RESP <= resp_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration outputs, wired straight from the storage flip-flops.

  assign PIN_CTRL.dir.a = store_r[`A_PORT_A_OUTPUT_LATCH_DIR][3:0];
  assign PIN_CTRL.dir.b = store_r[`A_PORT_B_OUTPUT_LATCH_DIR];
  assign PIN_CTRL.dir.c = store_r[`A_PORT_C_OUTPUT_LATCH_DIR];
  assign PIN_CTRL.dir.d = store_r[`A_PORT_D_OUTPUT_LATCH_DIR];
  assign PIN_CTRL.out.a = store_r[`A_PORT_A_OUTPUT_LATCH_OUT][3:0];
  assign PIN_CTRL.out.b = store_r[`A_PORT_B_OUTPUT_LATCH_OUT];
  assign PIN_CTRL.out.c = store_r[`A_PORT_C_OUTPUT_LATCH_OUT];
  assign PIN_CTRL.out.d = store_r[`A_PORT_D_OUTPUT_LATCH_OUT];
  assign PIN_CTRL.pullup_ctrl = store_r[`A_PULLUP_CTRL];

  assign PERIPH_CFG.ext_irq_mask = store_r[`A_EXT_MASK][1:0];
  assign PERIPH_CFG.eeprom_ctrl = store_r[`A_EE_CTRL][5:0];
  assign PERIPH_CFG.eeprom_data = store_r[`A_EE_DATA];
  assign PERIPH_CFG.eeprom_addr = store_r[`A_EE_ADDR];
  assign PERIPH_CFG.prescaler_ctrl = store_r[`A_PRESC_CTRL];
  assign PERIPH_CFG.timer0_ctrl = store_r[`A_T0_CTRL][3:0];
  assign PERIPH_CFG.timer0_count = store_r[`A_T0_COUNT];
  assign PERIPH_CFG.timer0_cmp_a = store_r[`A_T0_CMP_A];
  assign PERIPH_CFG.timer0_cmp_b = store_r[`A_T0_CMP_B];
  assign PERIPH_CFG.spi_ctrl = store_r[`A_SPI_CTRL];
  assign PERIPH_CFG.spi_double_speed = store_r[`A_SPI_STAT][0];

endmodule
`default_nettype wire

//--- hdl/io_space_consts.svh
// Address map, field masks, reset values and view limits of the lower I/O space.
// Overview of operation
// [R1] Software writes zero into reserved bit positions of any register it writes.
// [R2] Software never writes to an I/O address marked reserved.
// [R3] Addresses 0x00 to 0x1F accept single-bit set and clear; higher ones do not.
// [R4] Bit-accessible registers support skip-if-bit-set and skip-if-bit-clear tests.
// [R5] Some status flags clear on writing one; writing zero leaves them unchanged.
// [R6] Bit set or clear touches only the addressed bit, never other flags.
// [R7] Dedicated I/O read and write reach I/O addresses 0x00 to 0x3F.
// [R8] Data-space loads and stores see each I/O register at its address plus 0x20.
// [R9] The I/O address field holds 64 locations; nothing beyond is reachable by it.
// [R10] Extended registers at data 0x60 to 0xFF answer only loads and stores.
// [R11] Reserved bits and addresses read zero, ignore writes, have no side effects.
`ifndef IO_SPACE_CONSTS_SVH
`define IO_SPACE_CONSTS_SVH
`define IO_LOCATIONS 64
`define IO_BIT_TOP 6'h1f
`define DATA_IO_BASE 8'h20
`define DATA_EXT_BASE 8'h60
`define PIN_TO_LATCH 6'h02
`define RESET_BYTE 8'h00
`define A_PORT_B_OUTPUT_LATCH_PIN 6'h03
`define A_PORT_B_OUTPUT_LATCH_DIR 6'h04
`define A_PORT_B_OUTPUT_LATCH_OUT 6'h05
`define A_PORT_C_OUTPUT_LATCH_PIN 6'h06
`define A_PORT_C_OUTPUT_LATCH_DIR 6'h07
`define A_PORT_C_OUTPUT_LATCH_OUT 6'h08
`define A_PORT_D_OUTPUT_LATCH_PIN 6'h09
`define A_PORT_D_OUTPUT_LATCH_DIR 6'h0a
`define A_PORT_D_OUTPUT_LATCH_OUT 6'h0b
`define A_PORT_A_OUTPUT_LATCH_PIN 6'h0c
`define A_PORT_A_OUTPUT_LATCH_DIR 6'h0d
`define A_PORT_A_OUTPUT_LATCH_OUT 6'h0e
`define A_PULLUP_CTRL 6'h12
`define A_T0_FLAGS 6'h15
`define A_T1_FLAGS 6'h16
`define A_PC_FLAGS 6'h1b
`define A_EXT_FLAGS 6'h1c
`define A_EXT_MASK 6'h1d
`define A_GP0 6'h1e
`define A_EE_CTRL 6'h1f
`define A_EE_DATA 6'h20
`define A_EE_ADDR 6'h21
`define A_PRESC_CTRL 6'h23
`define A_T0_CTRL 6'h25
`define A_T0_COUNT 6'h26
`define A_T0_CMP_A 6'h27
`define A_T0_CMP_B 6'h28
`define A_GP1 6'h2a
`define A_GP2 6'h2b
`define A_SPI_CTRL 6'h2c
`define A_SPI_STAT 6'h2d
`define M_FULL 8'hff
`define M_PORT_A_OUTPUT_LATCH 8'h0f
`define M_T0_FLAGS 8'h07
`define M_T1_FLAGS 8'h27
`define M_PC_FLAGS 8'h0f
`define M_EXT 8'h03
`define M_EE_CTRL 8'h3f
`define M_PRESC 8'h81
`define M_T0_CTRL 8'h0f
`define M_SPI_STAT_W 8'h01
`define B_SPI_DONE 7
`define B_SPI_COLL 6
`endif

//--- hdl/io_space_pkg.sv
// Types shared by the I/O register space decoder and its users.
package io_space_pkg;

  typedef enum logic [2:0] {
    IO_READ_INSTR = 3'h0,
    IO_WRITE_INSTR = 3'h1,
    SET_IO_BIT_INSTR = 3'h3,
    CLEAR_IO_BIT_INSTR = 3'h2,
    SKIP_IF_BIT_SET_INSTR = 3'h6,
    SKIP_IF_BIT_CLEAR_INSTR = 3'h7,
    MEMORY_READ_OP = 3'h5,
    MEMORY_WRITE_OP = 3'h4
  } access_kind_e;

  typedef struct packed {
    logic valid;
    access_kind_e kind;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } io_req_s;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic skip;
    logic ext_sel;
  } io_resp_s;

  typedef struct packed {
    logic [3:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
  } port_pins_s;

  typedef struct packed {
    port_pins_s dir;
    port_pins_s out;
    logic [7:0] pullup_ctrl;
  } pin_ctrl_s;

  typedef struct packed {
    logic [7:0] t0;
    logic [7:0] t1;
    logic [7:0] pc;
    logic [7:0] ext;
  } flag_vec_s;

  typedef struct packed {
    logic [1:0] ext_irq_mask;
    logic [5:0] eeprom_ctrl;
    logic [7:0] eeprom_data;
    logic [7:0] eeprom_addr;
    logic [7:0] prescaler_ctrl;
    logic [3:0] timer0_ctrl;
    logic [7:0] timer0_count;
    logic [7:0] timer0_cmp_a;
    logic [7:0] timer0_cmp_b;
    logic [7:0] spi_ctrl;
    logic spi_double_speed;
  } periph_cfg_s;

endpackage

//--- hdl/w1c_flag_reg.sv
// Status flags set by hardware events and cleared by writing one.
`timescale 1ns/10ps
`default_nettype none
module w1c_flag_reg #(
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] set_ev,
  input wire logic [7:0] clr_ones,
  output logic [7:0] flags
);
  // A set arriving with its clear wins so that no event is lost.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      flags <= 8'h00;
    else
      flags <= ((flags & ~clr_ones) | set_ev) & MASK; // [R5] [R11]
  end
endmodule
`default_nettype wire

//--- verification/core_stub.sv
// Processor core stand-in that turns bench commands into register requests.
`timescale 1ns/10ps
`default_nettype none
module core_stub
  import io_space_pkg::*;
(
  input wire io_req_s cmd,
  output io_req_s req
);
  ////////////////////////////////////////////////////////////////////////////////
  wire logic mem = cmd.kind inside {MEMORY_READ_OP, MEMORY_WRITE_OP};
  wire logic [7:0] io_a = mem ? cmd.addr - 8'h20 : {2'b00, cmd.addr[5:0]};
  wire logic wr = cmd.kind inside {IO_WRITE_INSTR, SET_IO_BIT_INSTR, CLEAR_IO_BIT_INSTR,
    MEMORY_WRITE_OP};
  wire logic rsv = io_a inside {[8'h00:8'h02], [8'h0f:8'h11], 8'h13, 8'h14,
    [8'h17:8'h1a], 8'h22, 8'h24, 8'h29};
  // A write to a hole below 0x2E becomes a read; writes to 0x2E to 0x3F still pass through.
  always_comb
  begin
    req = cmd;
    if (wr && rsv)
      req.kind = mem ? MEMORY_READ_OP : IO_READ_INSTR;
  end
endmodule
`default_nettype wire

//--- verification/io_register_space_decode_test.sv
// Self-checking bench for the I/O register space decoder.
`timescale 1ns/10ps
`default_nettype none
module io_register_space_decode_test
  import io_space_pkg::*;
;
  logic CLK, RST_B, SPI_DONE, SPI_COLLISION;
  io_req_s cmd, REQ;
  port_pins_s PINS;
  flag_vec_s EVENTS, FLAGS;
  io_resp_s RESP;
  pin_ctrl_s PIN_CTRL;
  periph_cfg_s PERIPH_CFG;
  int n_mismatch, checked, i;
  logic [7:0] rd, d, ad;
  logic [5:0] a;
  logic [7:0] shadow [64];
  logic [5:0] store_a [23] = '{6'h04, 6'h05, 6'h07, 6'h08, 6'h0a, 6'h0b, 6'h0d, 6'h0e,
    6'h12, 6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h23, 6'h25, 6'h26, 6'h27, 6'h28, 6'h2a,
    6'h2b, 6'h2c, 6'h2d};
  io_register_space_decode i_io_register_space_decode (.CLK(CLK), .RST_B(RST_B), .REQ(REQ),
    .PINS(PINS), .EVENTS(EVENTS), .SPI_DONE(SPI_DONE), .SPI_COLLISION(SPI_COLLISION),
    .RESP(RESP), .PIN_CTRL(PIN_CTRL), .FLAGS(FLAGS), .PERIPH_CFG(PERIPH_CFG));
  core_stub i_core_stub (.cmd(cmd), .req(REQ));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] wmask(input logic [5:0] x);
    case (x)
      6'h0d, 6'h0e, 6'h25: return 8'h0f;
      6'h1d: return 8'h03;
      6'h1f: return 8'h3f;
      6'h23: return 8'h81;
      6'h2d: return 8'h01;
      default: return 8'hff;
    endcase
  endfunction
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One request per call; the answer stands for one cycle, so it is sampled just after.
  task automatic xfer(input access_kind_e k, input logic [7:0] adr, input logic [2:0] b,
    input logic [7:0] wd);
    @(posedge CLK);
    cmd <= '{1'b1, k, adr, b, wd};
    @(posedge CLK);
    cmd.valid <= 1'b0;
    #1;
    check("ack", 8'h01, {7'h00, RESP.ack});
    rd = RESP.rdata;
  endtask
  task automatic check_word(input string what, input logic [79:0] exp,
    input logic [79:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Expected configuration outputs, rebuilt from the bytes the bench has written.
  function automatic pin_ctrl_s exp_pins();
    return '{'{shadow[6'h0d][3:0], shadow[6'h04], shadow[6'h07], shadow[6'h0a]},
      '{shadow[6'h0e][3:0], shadow[6'h05], shadow[6'h08], shadow[6'h0b]}, shadow[6'h12]};
  endfunction
  function automatic periph_cfg_s exp_cfg();
    return '{shadow[6'h1d][1:0], shadow[6'h1f][5:0], shadow[6'h20], shadow[6'h21],
      shadow[6'h23], shadow[6'h25][3:0], shadow[6'h26], shadow[6'h27], shadow[6'h28],
      shadow[6'h2c], shadow[6'h2d][0]};
  endfunction
  task automatic tally_and_finish;
    $display("Counts: %0d compared, %0d mismatched", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  initial
  begin
    repeat (100000) @(posedge CLK);
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    RST_B = 1'b0;
    cmd = '0;
    PINS = '0;
    EVENTS = '0;
    SPI_DONE = 1'b0;
    SPI_COLLISION = 1'b0;
    n_mismatch = 0;
    checked = 0;
    shadow = '{default: 8'h00};
    i = $urandom(51);
    repeat (16) @(posedge CLK);
    RST_B <= 1'b1;
    for (i = 0; i < 64; i++)
    begin
      xfer(IO_READ_INSTR, i[7:0], 3'h0, 8'h00);
      check("reset read", 8'h00, rd);
    end
    $display("Test reset scan done");
    @(posedge CLK);
    PINS <= port_pins_s'($urandom);
    SPI_DONE <= 1'b1;
    SPI_COLLISION <= 1'b1;
    repeat (3) @(posedge CLK);
    xfer(IO_READ_INSTR, 8'h03, 3'h0, 8'h00);
    check("pins b", PINS.b, rd);
    xfer(MEMORY_READ_OP, 8'h2c, 3'h0, 8'h00);
    check("pins a", {4'h0, PINS.a}, rd);
    $display("Test pins done");
    // Random data is trimmed to the writable bits; reserved bits stay zero.
    for (i = 0; i < 60; i++)
    begin
      a = store_a[$urandom % 23];
      d = 8'($urandom) & wmask(a);
      shadow[a] = d;
      if ($urandom % 2)
      begin
        xfer(IO_WRITE_INSTR, {2'b11, a}, 3'h0, d);
        xfer(MEMORY_READ_OP, {2'b00, a} + 8'h20, 3'h0, 8'h00);
      end
      else
      begin
        xfer(MEMORY_WRITE_OP, {2'b00, a} + 8'h20, 3'h0, d);
        xfer(IO_READ_INSTR, {2'b00, a}, 3'h0, 8'h00);
      end
      check("two views", d | ((a == 6'h2d) ? 8'hc0 : 8'h00), rd);
    end
    check_word("pin ctrl", 80'(exp_pins()), 80'(PIN_CTRL));
    check_word("periph cfg", 80'(exp_cfg()), 80'(PERIPH_CFG));
    xfer(IO_WRITE_INSTR, 8'h1d, 3'h0, 8'hff);
    check("reserved bits", 8'h03, {6'h00, PERIPH_CFG.ext_irq_mask});
    $display("Test address views done");
    for (i = 0; i < 4; i++)
    begin
      ad = (i == 0) ? 8'h1f : (i == 1) ? 8'h5f : (i == 2) ? 8'h60 : 8'hff;
      xfer((i % 2) ? MEMORY_WRITE_OP : MEMORY_READ_OP, ad, 3'h0, 8'h5a);
      check("ext select", {7'h00, ad >= 8'h60}, {7'h00, RESP.ext_sel});
      check("ext data", 8'h00, rd);
    end
    $display("Test extended space done");
    xfer(IO_WRITE_INSTR, 8'h04, 3'h0, 8'h00);
    xfer(IO_WRITE_INSTR, 8'h2c, 3'h0, 8'h00);
    for (i = 0; i < 8; i++)
    begin
      xfer(SET_IO_BIT_INSTR, 8'h04, i[2:0], 8'h00);
      check("bit set", 8'h01 << i, PIN_CTRL.dir.b);
      xfer(SKIP_IF_BIT_SET_INSTR, 8'h04, i[2:0], 8'h00);
      check("skip set", 8'h01, {7'h00, RESP.skip});
      xfer(SKIP_IF_BIT_CLEAR_INSTR, 8'h04, i[2:0], 8'h00);
      check("skip clear", 8'h00, {7'h00, RESP.skip});
      xfer(CLEAR_IO_BIT_INSTR, 8'h04, i[2:0], 8'h00);
      check("bit clear", 8'h00, PIN_CTRL.dir.b);
      xfer(SET_IO_BIT_INSTR, 8'h2c, i[2:0], 8'h00);
      xfer(SKIP_IF_BIT_SET_INSTR, 8'h2c, i[2:0], 8'h00);
      check("high skip", 8'h00, {7'h00, RESP.skip});
    end
    xfer(IO_READ_INSTR, 8'h2c, 3'h0, 8'h00);
    check("high bit set", 8'h00, rd);
    check("high cfg", 8'h00, PERIPH_CFG.spi_ctrl);
    xfer(IO_WRITE_INSTR, 8'h05, 3'h0, 8'h00);
    xfer(IO_WRITE_INSTR, 8'h03, 3'h0, 8'h5a);
    check("pin toggle", 8'h5a, PIN_CTRL.out.b);
    xfer(SET_IO_BIT_INSTR, 8'h03, 3'h0, 8'h00);
    check("pin bit toggle", 8'h5b, PIN_CTRL.out.b);
    $display("Test bit access done");
    @(posedge CLK);
    EVENTS <= '1;
    @(posedge CLK);
    EVENTS <= '0;
    xfer(IO_WRITE_INSTR, 8'h15, 3'h0, 8'h00);
    check("flags zero write", 8'h07, FLAGS.t0);
    xfer(IO_WRITE_INSTR, 8'h15, 3'h0, 8'h02);
    check("flags one write", 8'h05, FLAGS.t0);
    xfer(CLEAR_IO_BIT_INSTR, 8'h15, 3'h0, 8'h00);
    check("flags bit clear", 8'h05, FLAGS.t0);
    xfer(SET_IO_BIT_INSTR, 8'h15, 3'h2, 8'h00);
    check("flags bit set", 8'h01, FLAGS.t0);
    xfer(MEMORY_WRITE_OP, 8'h36, 3'h0, 8'h21);
    check("t1 flags", 8'h06, FLAGS.t1);
    check("pc flags", 8'h0f, FLAGS.pc);
    xfer(IO_WRITE_INSTR, 8'h1c, 3'h0, 8'h01);
    check("ext flags", 8'h02, FLAGS.ext);
    $display("Test flags done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- verification/io_space_checker_assertions.sv
// Port-level checks for the I/O register space decoder.
`timescale 1ns/10ps
`default_nettype none
module io_space_checker
  import io_space_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire io_req_s REQ,
  input wire port_pins_s PINS,
  input wire flag_vec_s EVENTS,
  input wire logic SPI_DONE,
  input wire logic SPI_COLLISION,
  input wire io_resp_s RESP,
  input wire pin_ctrl_s PIN_CTRL,
  input wire flag_vec_s FLAGS,
  input wire periph_cfg_s PERIPH_CFG
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////////////////////////
  sequence io_req(k, a);
    REQ.valid && REQ.kind == k && REQ.addr[5:0] == a;
  endsequence
  sequence flag_req(k);
    io_req(k, 6'h15) ##0 EVENTS.t0 == 8'h00;
  endsequence
  ack_next_a: assert property (REQ.valid |=> RESP.ack)
    else $error("request not acknowledged");
  no_stray_ack_a: assert property (!REQ.valid |=> !RESP.ack)
    else $error("ack without request");
  ext_view_a: assert property (REQ.valid && REQ.kind inside {MEMORY_READ_OP,
    MEMORY_WRITE_OP} && REQ.addr >= 8'h60 |=> RESP.ext_sel && RESP.rdata == 8'h00)
    else $error("extended address not flagged");
  high_skip_a: assert property (REQ.valid && REQ.kind == SKIP_IF_BIT_SET_INSTR
    && REQ.addr[5:0] > 6'h1f |=> !RESP.skip) else $error("skip above bit range");
  skip_test_a: assert property (io_req(SKIP_IF_BIT_SET_INSTR, 6'h04) |=>
    RESP.skip == |(($past(PIN_CTRL.dir.b) >> $past(REQ.bit_sel)) & 8'h01))
    else $error("skip does not follow tested bit");
  flag_clear_a: assert property (flag_req(IO_WRITE_INSTR) |=>
    FLAGS.t0 == ($past(FLAGS.t0) & ~$past(REQ.wdata))) else $error("flag clear wrong");
  bit_only_a: assert property (flag_req(SET_IO_BIT_INSTR) |=>
    FLAGS.t0 == ($past(FLAGS.t0) & ~(8'h01 << $past(REQ.bit_sel))))
    else $error("bit set touched other flags");
  no_bit_high_a: assert property (io_req(SET_IO_BIT_INSTR, 6'h2c) |=>
    $stable(PERIPH_CFG.spi_ctrl)) else $error("bit access above range");
  data_view_a: assert property (REQ.valid && REQ.kind == MEMORY_WRITE_OP
    && REQ.addr == 8'h24 |=> PIN_CTRL.dir.b == $past(REQ.wdata))
    else $error("data view write missed");
  reserved_zero_a: assert property (io_req(IO_READ_INSTR, 6'h00)
    |=> RESP.rdata == 8'h00) else $error("reserved address read nonzero");
endmodule
bind io_register_space_decode io_space_checker i_chk (.CLK(CLK), .RST_B(RST_B),
  .REQ(REQ), .PINS(PINS), .EVENTS(EVENTS), .SPI_DONE(SPI_DONE),
  .SPI_COLLISION(SPI_COLLISION), .RESP(RESP), .PIN_CTRL(PIN_CTRL), .FLAGS(FLAGS),
  .PERIPH_CFG(PERIPH_CFG));
`default_nettype wire
